/* rtl/pld_pkg.sv */
/*
 * Shared constants for the lock detector: window timing, ring
 * oscillator table and output selector code.
 * Assumes a single 10 MHz system clock; reference and divided VCO
 * arrivals reach the block as one-cycle pulses on that clock.
 */
//
// How it works
// - detection runs only while the lock detect enable input is high.
// - with the source select low the window is a fixed one-shot of 10 ns, rounded up to one 100 ns clock cycle.
// - with the source select high the window comes from a ring oscillator timer.
// - the two-bit ring configuration field sets the ring oscillator period.
// - the two-bit duration field sets how many ring periods the window lasts.
// - ring test mode with selector 0111 puts the ring on output two and stops detection.
// - lock is declared after the programmed number of consecutive in-window arrivals.
// - on lock the locked flag (status bit zero) is set.
// - one arrival outside the window clears the locked flag at once.
// - the locked flag is a read-only output that nothing can write.
// - with always-route set the flag drives the shared pin continuously.
// - with auto-share set the pin shows the flag except during a serial read.
// - asymmetric window with late select expects the VCO edge after the reference.
// - asymmetric window without late select expects the VCO edge before it.
package pld_pkg;

    localparam int CLK_PERIOD_NS = 100;
    localparam int ANA_WIN_NS = 10;
    localparam int ANA_WIN_CYC_RAW =
        (ANA_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ANA_WIN_CYC = (ANA_WIN_CYC_RAW < 1) ? 1 : ANA_WIN_CYC_RAW;

    localparam int WIN_W = 7;
    localparam logic [WIN_W-1:0] ANA_WIN_LEN = WIN_W'(ANA_WIN_CYC);
    localparam logic [WIN_W-1:0] AGE_MAX = 7'h7f;

    // half period of the ring in clock cycles, per configuration code
    localparam logic [2:0] RING_HALF_0 = 3'h1;
    localparam logic [2:0] RING_HALF_1 = 3'h2;
    localparam logic [2:0] RING_HALF_2 = 3'h3;
    localparam logic [2:0] RING_HALF_3 = 3'h4;

    localparam logic [3:0] GPO_SEL_RING = 4'h7;

    typedef enum logic [1:0] {
        PLD_IDLE = 2'h1,
        PLD_WAIT = 2'h2
    } pld_state_e;

endpackage

/* rtl/pld_win_timer.sv */
/*
 * Window timer: ring oscillator model and window length select.
 * Assumes the ring toggles on the system clock and that the window
 * length is consumed by the lock detector one cycle after a change.
 */
`timescale 1ns/1ns
`default_nettype none
module pld_win_timer
    import pld_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    // configuration
    input wire logic ring_run_i,
    input wire logic src_digital_i,
    input wire logic [1:0] ring_cfg_i,
    input wire logic [1:0] win_dur_i,
    // results
    output logic [WIN_W-1:0] win_len_o,
    output logic ring_o
);

    function automatic logic [2:0] ring_half(input logic [1:0] cfg);
        case (cfg)
            2'h0: ring_half = RING_HALF_0;
            2'h1: ring_half = RING_HALF_1;
            2'h2: ring_half = RING_HALF_2;
            default: ring_half = RING_HALF_3;
        endcase
    endfunction

    logic [2:0] half_cnt_reg;
    logic [WIN_W-1:0] len_next;

    ////////////////////////////////////////////////////////////////////////
    // ring oscillator as a divider of the clock
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            half_cnt_reg <= 3'h0;
            ring_o <= 1'b0;
        end
        else if (!ring_run_i)
        begin
            half_cnt_reg <= 3'h0;
            ring_o <= 1'b0;
        end
        else if (half_cnt_reg + 3'h1 >= ring_half(ring_cfg_i))
        begin
            half_cnt_reg <= 3'h0;
            ring_o <= ~ring_o;
        end
        else
        begin
            half_cnt_reg <= half_cnt_reg + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // window length: ring period shifted left by the duration code, or fixed one-shot
    always_comb
    begin
        len_next = WIN_W'({ring_half(ring_cfg_i), 1'b0}) << win_dur_i;
        if (!src_digital_i)
        begin
            len_next = ANA_WIN_LEN;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            win_len_o <= ANA_WIN_LEN;
        end
        else
        begin
            win_len_o <= len_next;
        end
    end

    a_analog_len: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        !src_digital_i |=> win_len_o == ANA_WIN_LEN)
        else $error("analog window length wrong");

    a_digital_len: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        src_digital_i && ring_cfg_i == 2'h0 && win_dur_i == 2'h3
        |=> win_len_o == 7'h10)
        else $error("digital window length wrong");

endmodule
`default_nettype wire

/* rtl/pld_lock_detect.sv */
/*
 * Lock detector top: in-window check around each reference edge,
 * consecutive hit counter, locked flag and shared output pin mux.
 * Assumes ref_edge_i and vco_edge_i are one-cycle pulses synchronous
 * to ref_clk_i; control inputs are static or synchronous.
 */
`timescale 1ns/1ns
`default_nettype none
module pld_lock_detect
    import pld_pkg::*;
#(
    parameter int CNT_W = 10
)
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    // phase detector arrivals
    input wire logic ref_edge_i,
    input wire logic vco_edge_i,
    // lock detect control
    input wire logic lock_en_i,
    input wire logic src_digital_i,
    input wire logic [1:0] ring_cfg_i,
    input wire logic [1:0] win_dur_i,
    input wire logic ring_testmode_i,
    input wire logic [3:0] gpo_sel_i,
    input wire logic [CNT_W-1:0] win_count_max_i,
    input wire logic asym_en_i,
    input wire logic asym_late_i,
    // shared pin control
    input wire logic flag_pin_always_route_i,
    input wire logic flag_pin_auto_share_i,
    input wire logic serial_read_active_i,
    input wire logic serial_data_i,
    // status and pins
    output logic locked_flag_o,
    output logic [CNT_W-1:0] hit_count_o,
    output logic lockflag_serialout_pin_o,
    output logic general_output_two_o
);

    if (CNT_W < 1 || CNT_W > 16)
    begin : g_bad_width
        $error("CNT_W must lie in 1..16");
    end
    logic run;
    logic ring_test;
    logic ring;
    logic [WIN_W-1:0] win_len;
    logic [WIN_W-1:0] pre_len;
    logic [WIN_W-1:0] post_len;
    logic [WIN_W-1:0] age_reg;
    logic [WIN_W-1:0] post_cnt_reg;
    logic vco_avail_reg;
    logic pre_hit;
    logic hit;
    logic miss;
    logic open_wait;
    pld_state_e state_reg;
    assign ring_test = ring_testmode_i && (gpo_sel_i == GPO_SEL_RING);
    assign run = lock_en_i && !ring_test;
    pld_win_timer u_timer (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .ring_run_i(run || ring_test),
        .src_digital_i(src_digital_i),
        .ring_cfg_i(ring_cfg_i),
        .win_dur_i(win_dur_i),
        .win_len_o(win_len),
        .ring_o(ring)
    );

    ////////////////////////////////////////////////////////////////////////
    // split window before and after the reference edge
    always_comb
    begin
        pre_len = win_len >> 1;
        post_len = win_len - (win_len >> 1);
        if (asym_en_i && asym_late_i)
        begin
            pre_len = '0;
            post_len = win_len;
        end
        else if (asym_en_i)
        begin
            pre_len = win_len;
            post_len = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // verdict per reference cycle
    always_comb
    begin
        pre_hit = vco_edge_i || (vco_avail_reg && age_reg < pre_len);
        hit = 1'b0;
        miss = 1'b0;
        open_wait = 1'b0;
        if (run)
        begin
            if (state_reg == PLD_WAIT && vco_edge_i && !ref_edge_i)
            begin
                hit = 1'b1;
            end
            else if (state_reg == PLD_WAIT &&
                     (ref_edge_i || post_cnt_reg <= 7'h1))
            begin
                miss = 1'b1;
            end
            if (ref_edge_i)
            begin
                if (pre_hit && !miss)
                begin
                    hit = 1'b1;
                end
                else if (!pre_hit && post_len == '0)
                begin
                    miss = 1'b1;
                end
                else if (!pre_hit)
                begin
                    open_wait = 1'b1;
                end
            end
        end
    end
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state_reg <= PLD_IDLE;
            post_cnt_reg <= '0;
        end
        else if (!run)
        begin
            state_reg <= PLD_IDLE;
            post_cnt_reg <= '0;
        end
        else
        begin
            case (state_reg)
                PLD_IDLE:
                begin
                    if (open_wait)
                    begin
                        state_reg <= PLD_WAIT;
                        post_cnt_reg <= post_len;
                    end
                end
                PLD_WAIT:
                begin
                    if (open_wait)
                    begin
                        post_cnt_reg <= post_len;
                    end
                    else if (hit || miss)
                    begin
                        state_reg <= PLD_IDLE;
                    end
                    else
                    begin
                        post_cnt_reg <= post_cnt_reg - 7'h1;
                    end
                end
                default:
                begin
                    state_reg <= PLD_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // age of the last unused vco arrival
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            age_reg <= AGE_MAX;
            vco_avail_reg <= 1'b0;
        end
        else if (!run || hit)
        begin
            age_reg <= AGE_MAX;
            vco_avail_reg <= 1'b0;
        end
        else if (vco_edge_i)
        begin
            age_reg <= '0;
            vco_avail_reg <= 1'b1;
        end
        else if (age_reg != AGE_MAX)
        begin
            age_reg <= age_reg + 7'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // consecutive hit counter and locked flag
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            hit_count_o <= '0;
            locked_flag_o <= 1'b0;
        end
        else if (!run || miss)
        begin
            hit_count_o <= '0;
            locked_flag_o <= 1'b0;
        end
        else if (hit)
        begin
            if (hit_count_o != '1)
            begin
                hit_count_o <= hit_count_o + 1'b1;
            end
            if (hit_count_o + 1'b1 >= win_count_max_i)
            begin
                locked_flag_o <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shared pin and general output two
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            lockflag_serialout_pin_o <= 1'b0;
            general_output_two_o <= 1'b0;
        end
        else
        begin
            general_output_two_o <= ring_test && ring;
            if (flag_pin_always_route_i)
            begin
                lockflag_serialout_pin_o <= locked_flag_o;
            end
            else if (flag_pin_auto_share_i && !serial_read_active_i)
            begin
                lockflag_serialout_pin_o <= locked_flag_o;
            end
            else
            begin
                lockflag_serialout_pin_o <= serial_data_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_miss_seen;
        run && miss;
    endsequence
    sequence s_flag_and_count_clear;
        !locked_flag_o && hit_count_o == '0;
    endsequence
    a_miss_clears: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        s_miss_seen |=> s_flag_and_count_clear)
        else $error("miss did not clear flag and count");
    a_disabled_clear: assert property (@(posedge ref_clk_i)
        disable iff (!arst_n_i)
        !lock_en_i [*2] |-> s_flag_and_count_clear)
        else $error("flag or count set while disabled");
    a_test_suspends: assert property (@(posedge ref_clk_i)
        disable iff (!arst_n_i)
        ring_test |=> !locked_flag_o && state_reg == PLD_IDLE)
        else $error("detection active in ring test mode");
    a_lock_cause: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        $rose(locked_flag_o) |-> $past(hit) &&
        $past(hit_count_o) + 1'b1 >= $past(win_count_max_i))
        else $error("lock declared without enough hits");
    a_lock_sets: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        run && hit && !miss && hit_count_o + 1'b1 >= win_count_max_i
        |=> locked_flag_o)
        else $error("lock not declared at count");
    a_late_no_pre: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        run && asym_en_i && asym_late_i && ref_edge_i && !vco_edge_i
        && state_reg == PLD_IDLE |-> !hit)
        else $error("late window accepted early arrival");
    a_early_no_wait: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        run && asym_en_i && !asym_late_i && ref_edge_i && !pre_hit
        |-> miss ##1 !locked_flag_o)
        else $error("early window waited after reference");
    a_pin_always: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        flag_pin_always_route_i
        |=> lockflag_serialout_pin_o == $past(locked_flag_o))
        else $error("pin not showing flag");
    a_pin_share: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        !flag_pin_always_route_i && flag_pin_auto_share_i
        |=> lockflag_serialout_pin_o == ($past(serial_read_active_i) ?
            $past(serial_data_i) : $past(locked_flag_o)))
        else $error("shared pin mux wrong");
endmodule
`default_nettype wire

/* sim/pld_host_model.sv */
/*
 * Host side model: status reads over the serial port, watching the
 * shared lock flag / serial out pin.
 * Assumes the device samples its serial lines on the rising edge.
 */
`timescale 1ns/1ns
`default_nettype none
module pld_host_model
(
    // clock
    input wire logic clk_i,
    // shared pin from the device
    input wire logic pin_i,
    // serial port lines toward the device
    output logic read_active_o,
    output logic data_o
);
    logic [7:0] shreg = 8'h00;
    logic [7:0] rx = 8'h00;
    int tx_cnt = 0;

    initial
    begin
        read_active_o <= 1'b0;
        data_o <= 1'b0;
    end

    ////////////////////////////////////////
    // released data line toggles so a stale bit never passes
    always @(negedge clk_i)
    begin
        if (read_active_o)
            rx <= {rx[6:0], pin_i};
        if (tx_cnt > 0)
        begin
            read_active_o <= 1'b1;
            data_o <= shreg[7];
            shreg <= {shreg[6:0], 1'b0};
            tx_cnt <= tx_cnt - 1;
        end
        else
        begin
            read_active_o <= 1'b0;
            data_o <= ~data_o;
        end
    end

    task automatic read_byte(input logic [7:0] b, output logic [7:0] got);
        @(posedge clk_i);
        shreg <= b;
        tx_cnt <= 8;
        repeat (11) @(negedge clk_i);
        got = rx;
    endtask
endmodule
`default_nettype wire

/* sim/tb_pld_lock_detect.sv */
/*
 * Self-checking bench for the lock detector: random window setups,
 * long lock count, disable, ring test and shared pin modes.
 * Assumes arrivals as one-cycle pulses driven on the falling edge.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_pld_lock_detect;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic ref_e = 1'b0;
    logic vco_e = 1'b0;
    logic lock_en = 1'b1;
    logic src_dig = 1'b0;
    logic [1:0] ring_cfg = 2'h0;
    logic [1:0] win_dur = 2'h0;
    logic ring_tm = 1'b0;
    logic [3:0] gpo_sel = 4'h0;
    logic [9:0] wmax = 10'h002;
    logic asym_en = 1'b0;
    logic asym_late = 1'b0;
    logic f_always = 1'b0;
    logic f_share = 1'b0;
    logic sread;
    logic sdata;
    logic flag;
    logic [9:0] cnt;
    logic pin;
    logic out_two;
    logic prev;
    logic [7:0] b;
    logic [7:0] got;
    logic exp_flag = 1'b0;
    int exp_cnt = 0;
    int failures = 0;
    int tests_run = 0;
    int toggles;
    int dummy;
    bit run = 1'b1;

    always #50 clk = ~clk;

    pld_lock_detect #(.CNT_W(10)) i_dut (
        .ref_clk_i(clk), .arst_n_i(arst_n),
        .ref_edge_i(ref_e), .vco_edge_i(vco_e),
        .lock_en_i(lock_en), .src_digital_i(src_dig),
        .ring_cfg_i(ring_cfg), .win_dur_i(win_dur),
        .ring_testmode_i(ring_tm), .gpo_sel_i(gpo_sel),
        .win_count_max_i(wmax), .asym_en_i(asym_en),
        .asym_late_i(asym_late),
        .flag_pin_always_route_i(f_always),
        .flag_pin_auto_share_i(f_share),
        .serial_read_active_i(sread), .serial_data_i(sdata),
        .locked_flag_o(flag), .hit_count_o(cnt),
        .lockflag_serialout_pin_o(pin), .general_output_two_o(out_two)
    );

    pld_host_model i_host (
        .clk_i(clk), .pin_i(pin),
        .read_active_o(sread), .data_o(sdata)
    );

    ////////////////////////////////////////
    function automatic int win_len();
        return src_dig ? 2 * (ring_cfg + 1) * (1 << win_dur) : 1;
    endfunction

    function automatic int pre_len();
        if (asym_en)
            return asym_late ? 0 : win_len();
        return win_len() / 2;
    endfunction

    function automatic int post_len();
        return win_len() - pre_len();
    endfunction

    task automatic end_of_test();
        if (failures == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string name, input logic [9:0] e,
                       input logic [9:0] g);
        tests_run++;
        if (g !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", name, e, g);
            failures++;
        end
    endtask

    // one reference edge with a vco arrival at offset off
    task automatic trial(input int off, input bit hit);
        int s;
        s = win_len() + 4;
        for (int t = -s; t <= s; t++)
        begin
            @(negedge clk);
            ref_e = (t == 0);
            vco_e = (t == off);
        end
        @(negedge clk);
        ref_e = 1'b0;
        vco_e = 1'b0;
        repeat (2) @(negedge clk);
        if (run)
        begin
            exp_cnt = hit ? exp_cnt + 1 : 0;
            exp_flag = hit && exp_cnt >= int'(wmax);
        end
        chk("hit_count", 10'(exp_cnt), cnt);
        chk("locked_flag", 10'(exp_flag), 10'(flag));
    endtask

    ////////////////////////////////////////
    initial
    begin
        #(100 * 60000);
        failures++;
        end_of_test();
    end

    initial
    begin
        dummy = $urandom(32'h2aec2039);
        repeat (10) @(negedge clk);
        arst_n = 1'b1;
        chk("reset_cnt", 10'h000, cnt);
        chk("reset_out", 10'h000, {7'h00, flag, pin, out_two});
        trial(0, 1);
        trial(0, 1);
        trial(99, 0);
        wmax = 10'h3e8;
        repeat (1000) trial(0, 1);
        trial(99, 0);
        wmax = 10'h003;
        repeat (60)
        begin
            {src_dig, ring_cfg, win_dur, asym_en, asym_late} = 7'($urandom);
            case ($urandom % 5)
                0: trial(0, 1);
                1: trial(pre_len() > 0 ? -1 - int'($urandom % pre_len()) : 0, 1);
                2: trial(post_len() > 1 ? 1 + int'($urandom % (post_len() / 2)) : 0, 1);
                3: trial(post_len() + 2 + int'($urandom % 3), 0);
                default: trial(-pre_len() - 2 - int'($urandom % 3), 0);
            endcase
        end
        {src_dig, ring_cfg, win_dur, asym_en, asym_late} = 7'h00;
        repeat (3) trial(0, 1);
        lock_en = 1'b0;
        repeat (2) @(negedge clk);
        exp_cnt = 0;
        exp_flag = 1'b0;
        chk("disabled_cnt", 10'h000, cnt);
        chk("disabled_flag", 10'h000, 10'(flag));
        run = 1'b0;
        trial(0, 1);
        lock_en = 1'b1;
        run = 1'b1;
        repeat (3) trial(0, 1);
        ring_tm = 1'b1;
        gpo_sel = 4'h7;
        src_dig = 1'b1;
        exp_cnt = 0;
        exp_flag = 1'b0;
        run = 1'b0;
        toggles = 0;
        prev = out_two;
        repeat (40)
        begin
            @(negedge clk);
            if (out_two !== prev)
                toggles++;
            prev = out_two;
        end
        chk("ring_output", 10'h001, 10'(toggles > 3));
        trial(0, 1);
        gpo_sel = 4'h6;
        run = 1'b1;
        trial(0, 1);
        chk("out_two_idle", 10'h000, 10'(out_two));
        ring_tm = 1'b0;
        src_dig = 1'b0;
        wmax = 10'h000;
        trial(0, 1);
        for (int m = 0; m < 3; m++)
        begin
            f_always = (m == 0);
            f_share = (m == 1);
            b = 8'($urandom) & 8'hfe;
            i_host.read_byte(b, got);
            chk("pin_read", 10'(m == 0 ? 8'hff : b), 10'(got));
            if (m < 2)
                chk("pin_after", 10'h001, 10'(pin));
        end
        end_of_test();
    end
endmodule
`default_nettype wire
